/* txsd_top.sv */
// SPI register port for transmit fill status and bus clock divider
`default_nettype none
// How it works
// - Read command 0x80 returns status byte
// - Bit 2 set when 32 words held
// - Bit 1 set at 16 or more words
// - Bit 0 set when empty, one after reset
// - Status bits 7 to 3 read zero
// - Divider field bits 4:1, resets zero
module txsd_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic tx_word_load,
  input wire logic tx_word_remove,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic [3:0] bus_clock_div,
  output logic tx_buffer_full_flag,
  output logic tx_buffer_half_flag,
  output logic tx_buffer_empty_flag
);
  typedef enum logic [1:0] {
    TXSD_CMD,
    TXSD_READ,
    TXSD_WRITE,
    TXSD_IGNORE
  } txsd_state_t;

  logic [txsd_pkg::SYNC_STAGES-1:0] sclk_sync;
  logic [txsd_pkg::SYNC_STAGES-1:0] cs_sync;
  logic [txsd_pkg::SYNC_STAGES-1:0] mosi_sync;
  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic [7:0] in_shreg;
  logic [7:0] next_in;
  logic [7:0] out_shreg;
  logic [4:0] bit_count;
  txsd_state_t state;
  logic full_flag;
  logic half_flag;
  logic empty_flag;
  logic cmd_done;
  logic data_done;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_sync <= 2'b00;
      cs_sync <= 2'b11;
      mosi_sync <= 2'b00;
    end else if (ce) begin
      sclk_sync <= {sclk_sync[0], spi_sclk};
      cs_sync <= {cs_sync[0], spi_cs_n};
      mosi_sync <= {mosi_sync[0], spi_mosi};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_prev <= 1'b0;
    end else if (ce) begin
      sclk_prev <= sclk_sync[1];
    end
  end

  assign cs_active = !cs_sync[1];
  assign sclk_rise = cs_active && sclk_sync[1] && !sclk_prev;
  assign sclk_fall = cs_active && !sclk_sync[1] && sclk_prev;
  assign next_in = {in_shreg[6:0], mosi_sync[1]};
  assign cmd_done = sclk_rise && (bit_count == txsd_pkg::BITS_CMD - 5'h01);
  assign data_done = sclk_rise && (bit_count == txsd_pkg::BITS_DATA - 5'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Status byte with unused upper bits zero
  function automatic logic [7:0] txsd_status_byte(input logic f, input logic h,
                                                  input logic e);
    logic [7:0] b;
    b = 8'h00;
    b[txsd_pkg::BIT_FULL] = f;
    b[txsd_pkg::BIT_HALF] = h;
    b[txsd_pkg::BIT_EMPTY] = e;
    return b;
  endfunction

  function automatic logic [7:0] txsd_div_byte(input logic [3:0] d);
    logic [7:0] b;
    b = 8'h00;
    b[txsd_pkg::DIV_MSB:txsd_pkg::DIV_LSB] = d;
    return b;
  endfunction

  // Opcode to frame phase
  function automatic txsd_state_t txsd_decode(input logic [7:0] op);
    txsd_state_t s;
    case (op)
      txsd_pkg::OP_TX_STATUS_READ: s = TXSD_READ;
      txsd_pkg::OP_DIV_READ: s = TXSD_READ;
      txsd_pkg::OP_DIV_WRITE: s = TXSD_WRITE;
      default: s = TXSD_IGNORE;
    endcase
    return s;
  endfunction

  // Byte to shift out for a read opcode
  function automatic logic [7:0] txsd_read_byte(input logic [7:0] op,
                                                input logic [7:0] status,
                                                input logic [7:0] div);
    logic [7:0] b;
    b = 8'h00;
    if (op == txsd_pkg::OP_TX_STATUS_READ) begin
      b = status;
    end else if (op == txsd_pkg::OP_DIV_READ) begin
      b = div;
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter and input shift
  always_ff @(posedge clk) begin
    if (srst) begin
      bit_count <= 5'h00;
      in_shreg <= 8'h00;
    end else if (ce) begin
      if (!cs_active) begin
        bit_count <= 5'h00;
      end else if (sclk_rise) begin
        in_shreg <= next_in;
        if (bit_count != txsd_pkg::BITS_DATA) begin
          bit_count <= bit_count + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= TXSD_CMD;
    end else if (ce) begin
      if (!cs_active) begin
        state <= TXSD_CMD;
      end else if (cmd_done) begin
        state <= txsd_decode(next_in);
      end else if (data_done) begin
        state <= TXSD_IGNORE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider register
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_clock_div <= txsd_pkg::DIV_RESET;
    end else if (ce) begin
      if (state == TXSD_WRITE && data_done) begin
        bus_clock_div <= next_in[txsd_pkg::DIV_MSB:txsd_pkg::DIV_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, loaded after the command byte, shifted on falling edges
  always_ff @(posedge clk) begin
    if (srst) begin
      out_shreg <= 8'h00;
      spi_miso <= 1'b0;
    end else if (ce) begin
      if (!cs_active) begin
        out_shreg <= 8'h00;
        spi_miso <= 1'b0;
      end else if (cmd_done) begin
        out_shreg <= txsd_read_byte(next_in,
                                    txsd_status_byte(full_flag, half_flag, empty_flag),
                                    txsd_div_byte(bus_clock_div));
      end else if (sclk_fall && state == TXSD_READ) begin
        spi_miso <= out_shreg[7];
        out_shreg <= {out_shreg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      spi_miso_oe <= 1'b0;
    end else if (ce) begin
      spi_miso_oe <= cs_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fill tracking and flag outputs
  txsd_fill u_fill (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .word_load(tx_word_load),
    .word_remove(tx_word_remove),
    .full_flag(full_flag),
    .half_flag(half_flag),
    .empty_flag(empty_flag)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_buffer_full_flag <= txsd_pkg::FULL_RESET;
      tx_buffer_half_flag <= txsd_pkg::HALF_RESET;
      tx_buffer_empty_flag <= txsd_pkg::EMPTY_RESET;
    end else if (ce) begin
      tx_buffer_full_flag <= full_flag;
      tx_buffer_half_flag <= half_flag;
      tx_buffer_empty_flag <= empty_flag;
    end
  end
endmodule
`default_nettype wire

/* txsd_pkg.sv */
// Constants for the transmit status and bus clock divider registers
`default_nettype none
package txsd_pkg;
  localparam logic [7:0] OP_TX_STATUS_READ = 8'h80;
  localparam logic [7:0] OP_DIV_WRITE = 8'h38;
  localparam logic [7:0] OP_DIV_READ = 8'hB8;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_HALF = 16;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
  localparam logic [CNT_W-1:0] CNT_HALF = 6'h10;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam int BIT_FULL = 2;
  localparam int BIT_HALF = 1;
  localparam int BIT_EMPTY = 0;
  localparam int DIV_LSB = 1;
  localparam int DIV_MSB = 4;
  localparam logic [3:0] DIV_RESET = 4'h0;
  localparam logic FULL_RESET = 1'b0;
  localparam logic HALF_RESET = 1'b0;
  localparam logic EMPTY_RESET = 1'b1;
  localparam logic [4:0] BITS_CMD = 5'h08;
  localparam logic [4:0] BITS_DATA = 5'h10;
  localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

/* txsd_fill.sv */
// Transmit buffer occupancy counter and fill flags
`default_nettype none
module txsd_fill (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic word_load,
  input wire logic word_remove,
  output logic full_flag,
  output logic half_flag,
  output logic empty_flag
);
  logic [txsd_pkg::CNT_W-1:0] count;
  logic [txsd_pkg::CNT_W-1:0] next_count;
  logic do_load;
  logic do_remove;

  assign do_load = word_load && (count != txsd_pkg::CNT_FULL);
  assign do_remove = word_remove && (count != txsd_pkg::CNT_RESET);

  always_comb begin
    next_count = count;
    if (do_load && !do_remove) begin
      next_count = count + 6'h01;
    end else if (do_remove && !do_load) begin
      next_count = count - 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= txsd_pkg::CNT_RESET;
    end else if (ce) begin
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags are registered from the next count, so they change on the same edge as the count
  always_ff @(posedge clk) begin
    if (srst) begin
      full_flag <= txsd_pkg::FULL_RESET;
      half_flag <= txsd_pkg::HALF_RESET;
      empty_flag <= txsd_pkg::EMPTY_RESET;
    end else if (ce) begin
      full_flag <= (next_count == txsd_pkg::CNT_FULL);
      half_flag <= (next_count >= txsd_pkg::CNT_HALF);
      empty_flag <= (next_count == txsd_pkg::CNT_RESET);
    end
  end
endmodule
`default_nettype wire

/* txsd_monitor.sv */
// Checker on the fill flags, divider and SPI select
`default_nettype none
module txsd_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic spi_cs_n,
  input wire logic tx_word_load,
  input wire logic tx_word_remove,
  input wire logic spi_miso_oe,
  input wire logic [3:0] bus_clock_div,
  input wire logic tx_buffer_full_flag,
  input wire logic tx_buffer_half_flag,
  input wire logic tx_buffer_empty_flag
);
  logic [5:0] cnt;
  logic do_ld;
  logic do_rm;
  assign do_ld = tx_word_load && (cnt != 6'h20);
  assign do_rm = tx_word_remove && (cnt != 6'h00);
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 6'h00;
    end else if (ce && do_ld && !do_rm) begin
      cnt <= cnt + 6'h01;
    end else if (ce && do_rm && !do_ld) begin
      cnt <= cnt - 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_full;
    !$past(srst) && $past(ce) && $past(ce, 2) |-> tx_buffer_full_flag == ($past(cnt) == 6'h20);
  endproperty
  a_full: assert property (p_full) else $error("full flag wrong");
  property p_half;
    !$past(srst) && $past(ce) && $past(ce, 2) |-> tx_buffer_half_flag == ($past(cnt) >= 6'h10);
  endproperty
  a_half: assert property (p_half) else $error("half flag wrong");
  property p_empty;
    !$past(srst) && $past(ce) && $past(ce, 2) |-> tx_buffer_empty_flag == ($past(cnt) == 6'h00);
  endproperty
  a_empty: assert property (p_empty) else $error("empty flag wrong");
  property p_rst; $past(srst) |-> bus_clock_div == 4'h0 && tx_buffer_empty_flag; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_idle; spi_cs_n [*5] |-> !spi_miso_oe; endproperty
  a_idle: assert property (p_idle) else $error("miso driven while idle");
  property p_div; spi_cs_n [*5] |-> $stable(bus_clock_div); endproperty
  a_div: assert property (p_div) else $error("divider moved while idle");
  property p_sel; !spi_cs_n [*5] |-> spi_miso_oe; endproperty
  a_sel: assert property (p_sel) else $error("miso not driven while selected");
  property p_upd;
    ce && tx_word_load && !tx_word_remove && cnt == 6'h00 ##1 ce |-> ##1 !tx_buffer_empty_flag;
  endproperty
  a_upd: assert property (p_upd) else $error("empty flag late");
  c_full: cover property (tx_buffer_full_flag);
  c_div: cover property ($changed(bus_clock_div));
  c_sel: cover property ($fell(spi_cs_n));
endmodule
bind txsd_top txsd_monitor u_txsd_monitor (.clk, .srst, .ce, .spi_cs_n, .tx_word_load,
  .tx_word_remove, .spi_miso_oe, .bus_clock_div, .tx_buffer_full_flag,
  .tx_buffer_half_flag, .tx_buffer_empty_flag);
`default_nettype wire

/* txsd_host.sv */
// SPI host model, mode 0, MSB first
`default_nettype none
module txsd_host (
  input wire logic clk,
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Command byte then data byte, second byte sampled on rising edges
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = tx[i];
      tick(6);
      spi_sclk = 1'b1;
      if (i < 8) rx[i] = spi_miso;
      tick(6);
      spi_sclk = 1'b0;
    end
    tick(6);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    tick(6);
  endtask
endmodule
`default_nettype wire

/* tb_tx_status_and_clock_divider.sv */
// Bench for the fill status and divider registers
`default_nettype none
module tb_tx_status_and_clock_divider;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic ld = 1'b0;
  logic rm = 1'b0;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic tx_buffer_full_flag, tx_buffer_half_flag, tx_buffer_empty_flag;
  logic [3:0] bus_clock_div;
  logic [7:0] rx;
  int cnt = 0;
  int n_fail = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  txsd_top u_txsd_top (.clk, .srst, .ce, .spi_sclk, .spi_cs_n, .spi_mosi,
    .tx_word_load(ld), .tx_word_remove(rm), .spi_miso, .spi_miso_oe, .bus_clock_div,
    .tx_buffer_full_flag, .tx_buffer_half_flag, .tx_buffer_empty_flag);
  txsd_host u_txsd_host (.clk, .spi_miso, .spi_sclk, .spi_cs_n, .spi_mosi);
  task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic pulse(input logic l, input logic r);
    ld = l;
    rm = r;
    @(posedge clk);
    #1;
    ld = 1'b0;
    rm = 1'b0;
    if (l && (!r || cnt == 0) && cnt < 32) cnt++;
    else if (r && (!l || cnt == 32) && cnt > 0) cnt--;
    @(posedge clk);
    #1;
  endtask
  task automatic chk_status();
    logic [7:0] e;
    e = {5'h00, cnt == 32, cnt >= 16, cnt == 0};
    cmp(e, {5'h00, tx_buffer_full_flag, tx_buffer_half_flag, tx_buffer_empty_flag});
    u_txsd_host.xfer(16'h8000, rx);
    cmp(e, rx);
  endtask
  task automatic t_reset();
    cmp(8'h00, {4'h0, bus_clock_div});
    chk_status();
  endtask
  // Counts 15, 16, 31, 32, refused load, 16, 0, refused removal
  task automatic t_fill();
    int st[8] = '{15, 1, 15, 1, 1, -16, -16, -1};
    foreach (st[k]) begin
      repeat ((st[k] < 0) ? -st[k] : st[k]) pulse(st[k] > 0, st[k] < 0);
      chk_status();
    end
    pulse(1'b1, 1'b1);
    chk_status();
    pulse(1'b1, 1'b1);
    chk_status();
  endtask
  // Load pulses while the clock enable is low change nothing
  task automatic t_hold();
    ce = 1'b0;
    ld = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    ld = 1'b0;
    ce = 1'b1;
    @(posedge clk);
    #1;
    chk_status();
  endtask
  // Reset in mid-run with a nonzero divider and fill count
  task automatic t_midreset();
    u_txsd_host.xfer({txsd_pkg::OP_DIV_WRITE, 8'h14}, rx);
    pulse(1'b1, 1'b0);
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    cnt = 0;
    t_reset();
  endtask
  task automatic t_div();
    logic [7:0] d[3] = '{8'hFF, 8'h14, 8'h00};
    foreach (d[k]) begin
      u_txsd_host.xfer({txsd_pkg::OP_DIV_WRITE, d[k]}, rx);
      cmp({4'h0, d[k][4:1]}, {4'h0, bus_clock_div});
      u_txsd_host.xfer({txsd_pkg::OP_DIV_READ, 8'h00}, rx);
      cmp(d[k] & 8'h1E, rx);
    end
    u_txsd_host.xfer(16'h55AA, rx);
    cmp(8'h00, rx);
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_fill();
    t_hold();
    t_div();
    t_midreset();
    print_verdict();
  end
endmodule
`default_nettype wire
